// [core/rtc_window_map.svh]
// Purpose: offsets, field positions, reset values and keys of the
//          calendar register window block
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes:   16-bit registers sit in the low half of each word
//
// Behaviour
// - time pointer in config bits 9:8 picks time pair shown in window
// - time pointer 00 min/sec, 01 wday/hour, 10 month/day, 11 -/year
// - alarm pointer in alarm config bits 9:8 picks alarm pair in window
// - alarm pointer 00 min/sec, 01 wday/hour, 10 month/day, 11 none
// - time window high-byte write decrements time pointer, sticks at 00
// - alarm window high-byte write decrements alarm pointer, sticks at 00
// - any read of alarm window high or low byte decrements alarm pointer
// - any read of time window high or low byte decrements time pointer
// - low-byte writes never decrement; low-byte decrement is read only
// - time registers accept writes only while write enable bit 13 set
// - write enable set only right after key 55h then aah sequence
// - source select 00 secondary, 01 rc, 10 50 hz, 11 60 hz mains
`ifndef RTC_WINDOW_MAP_SVH
`define RTC_WINDOW_MAP_SVH

`define OFS_CAL_CFG 8'h00
`define OFS_ALM_CFG 8'h04
`define OFS_TIME_WIN 8'h08
`define OFS_ALM_WIN 8'h0c
`define OFS_PWR_CTL 8'h10
`define OFS_UNLOCK_KEY 8'h14

`define BIT_PTR_LO 8
`define BIT_WREN 13
`define BIT_SRC_LO 0

`define KEY_FIRST 8'h55
`define KEY_SECOND 8'haa
`define UNLOCK_WINDOW_CYC 2'd2

`define RST_PTR 2'h0
`define RST_SRC 2'h0
`define RST_BYTE 8'h00

`endif

// [core/rtc_window_pkg.sv]
// Purpose: types of the calendar register window block
// Assumes: used with rtc_window_map.svh
// Notes:   nothing is imported; names are written in full
package rtc_window_pkg;

   // reference clock choice
   typedef enum logic [1:0] {
      src_secondary = 2'b00,
      src_rc = 2'b01,
      src_mains_50 = 2'b10,
      src_mains_60 = 2'b11
   } src_type;

   // unlock sequence progress
   typedef enum logic [1:0] {
      key_idle = 2'b00,
      key_got_first = 2'b01,
      key_open = 2'b10
   } key_state_type;

   // one register pair as seen through a window
   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
   } byte_pair_type;

   // one pointer window state
   typedef struct packed {
      logic [1:0] ptr;
      byte_pair_type pair0;
      byte_pair_type pair1;
      byte_pair_type pair2;
      logic [7:0] lone;
   } window_type;

   // byte access on a window
   typedef struct packed {
      logic rd;
      logic wr;
      logic [1:0] be;
      logic [15:0] wdata;
      logic allow_wr;
   } win_access_type;

endpackage : rtc_window_pkg

// [core/value_window.sv]
// Purpose: one pointer-indexed 16-bit window over three byte pairs
// Assumes: access strobes are single-cycle pulses from the bus slave
// Notes:   pointer 11 shows an optional lone low byte
`timescale 1ns/10ps
`include "rtc_window_map.svh"

module value_window #(
   parameter bit HAS_LONE = 1'b1
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // access
   input rtc_window_pkg::win_access_type acc,
   input wire logic ptr_wr,
   input wire logic [1:0] ptr_wdata,
   // view
   output logic [1:0] ptr,
   output logic [15:0] rdata
);

   rtc_window_pkg::window_type st_ff, nxt_st;

   assign ptr = st_ff.ptr;

   // window mux by pointer
   always_comb begin
      unique case (st_ff.ptr)
         2'b00: rdata = st_ff.pair0;
         2'b01: rdata = st_ff.pair1;
         2'b10: rdata = st_ff.pair2;
         2'b11: rdata = {8'h00, HAS_LONE ? st_ff.lone : 8'h00};
      endcase
   end

   // byte writes and pointer stepping
   always_comb begin
      nxt_st = st_ff;
      if (acc.wr && acc.allow_wr) begin
         unique case (st_ff.ptr)
            2'b00: begin
               if (acc.be[1]) nxt_st.pair0.hi = acc.wdata[15:8];
               if (acc.be[0]) nxt_st.pair0.lo = acc.wdata[7:0];
            end
            2'b01: begin
               if (acc.be[1]) nxt_st.pair1.hi = acc.wdata[15:8];
               if (acc.be[0]) nxt_st.pair1.lo = acc.wdata[7:0];
            end
            2'b10: begin
               if (acc.be[1]) nxt_st.pair2.hi = acc.wdata[15:8];
               if (acc.be[0]) nxt_st.pair2.lo = acc.wdata[7:0];
            end
            2'b11: begin
               if (acc.be[0] && HAS_LONE) nxt_st.lone = acc.wdata[7:0];
            end
         endcase
      end
      if (((acc.wr && acc.be[1]) || acc.rd) && st_ff.ptr != 2'b00)
         nxt_st.ptr = st_ff.ptr - 2'b01;
      if (ptr_wr)
         nxt_st.ptr = ptr_wdata;
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

endmodule : value_window

// [core/calendar_clock_unit.sv]
// Purpose: register front end of the calendar clock: pointer windows,
//          unlock-guarded write enable and reference clock choice
// Assumes: AXI4-Lite slave, one write and one read in flight at most
// Notes:   window reads and high-byte writes move the pointers;
//          every bus answer and ready comes straight from a flop;
//          time window writes are dropped while the enable is clear
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "rtc_window_map.svh"

module calendar_clock_unit (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // calendar status
   output logic time_write_enable,
   output rtc_window_pkg::src_type time_source_select
);

   //------------------------------------------------------------------
   // state and wiring
   //------------------------------------------------------------------

   // bus and control state
   typedef struct packed {
      logic awready;
      logic wready;
      logic arready;
      logic aw_have;
      logic [7:0] awaddr;
      logic w_have;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic wren;
      rtc_window_pkg::src_type src;
      rtc_window_pkg::key_state_type key;
      logic [1:0] key_cnt;
   } unit_state_type;

   // one struct holds every flop of the unit outside the two window instances
   unit_state_type st_ff, nxt_st;

   // strobes and views between the bus and the two windows
   logic do_wr;
   logic do_rd;
   logic [1:0] tptr;
   logic [1:0] aptr;
   logic [15:0] t_rdata;
   logic [15:0] a_rdata;
   rtc_window_pkg::win_access_type t_acc, a_acc;
   logic t_ptr_wr, a_ptr_wr;
   logic [1:0] w_be;
   logic [15:0] rd_word;
   logic rd_ok;
   logic wr_ok;

   //------------------------------------------------------------------
   // bus outputs
   //------------------------------------------------------------------

   // bus handshakes, all straight from the state flops
   assign s_axi_awready = st_ff.awready;
   assign s_axi_wready = st_ff.wready;
   assign s_axi_arready = st_ff.arready;
   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_rvalid = st_ff.rvalid;
   assign s_axi_rdata = st_ff.rdata;
   assign s_axi_rresp = st_ff.rresp;
   // status pins
   assign time_write_enable = st_ff.wren;
   assign time_source_select = st_ff.src;

   // write fires once address and data are both held; holding each
   // half lets the master offer address and data in either order
   assign do_wr = st_ff.aw_have && st_ff.w_have && !st_ff.bvalid;
   // a read is taken and answered at the address handshake
   assign do_rd = s_axi_arvalid && st_ff.arready;
   // only the low two strobes matter: registers are 16 bits wide
   assign w_be = st_ff.wstrb[1:0];

   //------------------------------------------------------------------
   // write decode and window strobes
   //------------------------------------------------------------------

   // address decode for writes; any other offset gets a slave error
   always_comb begin
      unique case (st_ff.awaddr)
         `OFS_CAL_CFG, `OFS_ALM_CFG, `OFS_TIME_WIN, `OFS_ALM_WIN,
         `OFS_PWR_CTL, `OFS_UNLOCK_KEY: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   // window access strobes; both windows see the same strobes and
   // data, and only the matching offset raises a read or write
   always_comb begin
      t_acc = '0;
      a_acc = '0;
      t_acc.rd = do_rd && s_axi_araddr == `OFS_TIME_WIN;
      a_acc.rd = do_rd && s_axi_araddr == `OFS_ALM_WIN;
      t_acc.wr = do_wr && st_ff.awaddr == `OFS_TIME_WIN;
      a_acc.wr = do_wr && st_ff.awaddr == `OFS_ALM_WIN;
      t_acc.be = w_be;
      a_acc.be = w_be;
      t_acc.wdata = st_ff.wdata[15:0];
      a_acc.wdata = st_ff.wdata[15:0];
      t_acc.allow_wr = st_ff.wren;
      // alarm values are not guarded: only the running time needs it
      a_acc.allow_wr = 1'b1;
   end

   //------------------------------------------------------------------
   // pointer windows
   //------------------------------------------------------------------

   // pointer fields share the high strobe with the enable bit, so a
   // config write of the low byte alone leaves both untouched
   // pointer fields of calendar config and alarm config
   assign t_ptr_wr = do_wr && st_ff.awaddr == `OFS_CAL_CFG && w_be[1];
   assign a_ptr_wr = do_wr && st_ff.awaddr == `OFS_ALM_CFG && w_be[1];

   // time window
   // the lone byte at pointer 11 holds the year
   value_window #(
      .HAS_LONE(1'b1)
   ) u_time_win (
      .aclk(aclk),
      .aresetn(aresetn),
      .acc(t_acc),
      .ptr_wr(t_ptr_wr),
      .ptr_wdata(st_ff.wdata[`BIT_PTR_LO+1:`BIT_PTR_LO]),
      .ptr(tptr),
      .rdata(t_rdata)
   );

   // alarm window
   // nothing is mapped at pointer 11
   value_window #(
      .HAS_LONE(1'b0)
   ) u_alarm_win (
      .aclk(aclk),
      .aresetn(aresetn),
      .acc(a_acc),
      .ptr_wr(a_ptr_wr),
      .ptr_wdata(st_ff.wdata[`BIT_PTR_LO+1:`BIT_PTR_LO]),
      .ptr(aptr),
      .rdata(a_rdata)
   );

   //------------------------------------------------------------------
   // read path
   //------------------------------------------------------------------

   // read mux on the offered address; a window read moves its pointer
   // at this same handshake, so the pair returned is the one shown
   // before the step
   always_comb begin
      rd_word = 16'h0000;
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         `OFS_CAL_CFG: begin
            rd_word[`BIT_WREN] = st_ff.wren;
            rd_word[`BIT_PTR_LO+1:`BIT_PTR_LO] = tptr;
         end
         `OFS_ALM_CFG: rd_word[`BIT_PTR_LO+1:`BIT_PTR_LO] = aptr;
         `OFS_TIME_WIN: rd_word = t_rdata;
         `OFS_ALM_WIN: rd_word = a_rdata;
         `OFS_PWR_CTL: rd_word[`BIT_SRC_LO+1:`BIT_SRC_LO] = st_ff.src;
         // key register reads zero so the key never shows on the bus
         `OFS_UNLOCK_KEY: rd_word = 16'h0000;
         default: rd_ok = 1'b0;
      endcase
   end

   //------------------------------------------------------------------
   // next state
   //------------------------------------------------------------------

   // bus, key sequence and control registers
   always_comb begin
      nxt_st = st_ff;
      // capture each write half as it is offered
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_st.aw_have = 1'b1;
         nxt_st.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_st.w_have = 1'b1;
         nxt_st.wdata = s_axi_wdata;
         nxt_st.wstrb = s_axi_wstrb;
      end
      // answers stand until the master takes them
      if (st_ff.bvalid && s_axi_bready)
         nxt_st.bvalid = 1'b0;
      if (st_ff.rvalid && s_axi_rready)
         nxt_st.rvalid = 1'b0;
      // unlock window closes after a short count, so a stray
      // config write long after the key cannot arm the enable
      if (st_ff.key == rtc_window_pkg::key_open) begin
         if (st_ff.key_cnt == 2'd0)
            nxt_st.key = rtc_window_pkg::key_idle;
         else
            nxt_st.key_cnt = st_ff.key_cnt - 2'd1;
      end
      // write execution: answer, key sequence and control fields
      if (do_wr) begin
         nxt_st.aw_have = 1'b0;
         nxt_st.w_have = 1'b0;
         nxt_st.bvalid = 1'b1;
         // unmapped places answer with a slave error
         nxt_st.bresp = wr_ok ? 2'b00 : 2'b10;
         // any other write breaks the key sequence
         // so the enable can only follow the key directly
         if (st_ff.awaddr != `OFS_CAL_CFG)
            nxt_st.key = rtc_window_pkg::key_idle;
         if (st_ff.awaddr == `OFS_UNLOCK_KEY && w_be[0]) begin
            // key sequence
            // a wrong byte drops the sequence back to the start
            if (st_ff.wdata[7:0] == `KEY_FIRST)
               nxt_st.key = rtc_window_pkg::key_got_first;
            else if (st_ff.wdata[7:0] == `KEY_SECOND &&
                     st_ff.key == rtc_window_pkg::key_got_first) begin
               nxt_st.key = rtc_window_pkg::key_open;
               nxt_st.key_cnt = `UNLOCK_WINDOW_CYC;
            end else
               nxt_st.key = rtc_window_pkg::key_idle;
         end
         if (st_ff.awaddr == `OFS_CAL_CFG && w_be[1]) begin
            // set only while open, clear always: locking the time
            // again must never depend on the key
            if (!st_ff.wdata[`BIT_WREN])
               nxt_st.wren = 1'b0;
            else if (st_ff.key == rtc_window_pkg::key_open)
               nxt_st.wren = 1'b1;
            nxt_st.key = rtc_window_pkg::key_idle;
         end
         if (st_ff.awaddr == `OFS_PWR_CTL && w_be[0]) begin
            // reference clock choice; all four codes are legal
            // so the field is taken as written
            nxt_st.src = rtc_window_pkg::src_type'(
               st_ff.wdata[`BIT_SRC_LO+1:`BIT_SRC_LO]);
         end
      end
      // read data is captured once and stands until taken
      if (do_rd) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata = {16'h0000, rd_word};
         nxt_st.rresp = rd_ok ? 2'b00 : 2'b10;
      end
      // readies from the next state: a flop one edge ahead gives the
      // same timing as a decode of the present state, without a path
      // from the state through logic to the bus pins
      nxt_st.awready = !nxt_st.aw_have && !nxt_st.bvalid;
      nxt_st.wready = !nxt_st.w_have && !nxt_st.bvalid;
      nxt_st.arready = !nxt_st.rvalid;
   end

   //------------------------------------------------------------------
   // state register
   //------------------------------------------------------------------

   // state register; readies stand high in and out of reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '0;
         st_ff.awready <= 1'b1;
         st_ff.wready <= 1'b1;
         st_ff.arready <= 1'b1;
         st_ff.src <= rtc_window_pkg::src_secondary;
         st_ff.key <= rtc_window_pkg::key_idle;
      end else begin
         st_ff <= nxt_st;
      end
   end

endmodule : calendar_clock_unit

// [verification/calendar_clock_unit_checker.sv]
// Purpose: port checks of the calendar clock unit
// Assumes: one clock domain, sync reset
// Notes:   bound onto every instance of the top module
`timescale 1ns/10ps
`include "rtc_window_map.svh"

module calendar_clock_unit_checker (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write channels
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   // read channels
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   // status
   input wire logic time_write_enable,
   input rtc_window_pkg::src_type time_source_select
);
   logic wr_go;
   logic rd_go;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // handshakes of both channels
   assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready;
   assign rd_go = s_axi_arvalid && s_axi_arready;

   AST_B_LAT: assert property (wr_go |-> ##2 s_axi_bvalid)
      else $error("write response late");
   AST_R_LAT: assert property (rd_go |=> s_axi_rvalid)
      else $error("read response late");
   AST_B_BLOCK: assert property (s_axi_bvalid |->
      !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   AST_TIME_OK: assert property (rd_go &&
      s_axi_araddr == `OFS_TIME_WIN |=> s_axi_rresp == 2'b00)
      else $error("time window read refused");
   AST_UNMAP_RD: assert property (rd_go && s_axi_araddr[7:2] > 6'h05 |=>
      s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   AST_UNMAP_WR: assert property (wr_go && s_axi_awaddr[7:2] > 6'h05 |->
      ##2 s_axi_bresp == 2'b10)
      else $error("unmapped write not refused");
   AST_WREN_RISE: assert property ($rose(time_write_enable) |->
      ##[0:1] s_axi_bvalid)
      else $error("write enable rose without a write");
   AST_SRC_CHG: assert property ($changed(time_source_select) |->
      ##[0:1] s_axi_bvalid)
      else $error("source changed without a write");

   // main scenarios
   cover property ($rose(time_write_enable));
   cover property (rd_go && s_axi_araddr == `OFS_ALM_WIN);
   cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule : calendar_clock_unit_checker

bind calendar_clock_unit calendar_clock_unit_checker
   calendar_clock_unit_checker_i (.aclk, .aresetn, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .time_write_enable, .time_source_select);

// [verification/tb_calendar_clock_unit.sv]
// Purpose: register level test of the calendar clock unit
// Assumes: bready and rready held high throughout
// Notes:   expected values follow the pointer walk
`timescale 1ns/10ps
`include "rtc_window_map.svh"

module tb_calendar_clock_unit;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, wren;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   rtc_window_pkg::src_type src;
   int n_mismatch, tests_run, i;
   logic [15:0] tv [5] = '{16'h0099, 16'h0c1f, 16'h0317, 16'h2d1e, 16'h2d1e};
   logic [15:0] av [4] = '{16'haabb, 16'h0102, 16'h0304, 16'h0506};

   calendar_clock_unit calendar_clock_unit_i (.aclk, .aresetn,
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .time_write_enable(wren),
      .time_source_select(src));

   // 100 MHz clock
   initial begin
      aclk = 0;
      forever #5 aclk = ~aclk;
   end

   // compare and count
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask : chk

   // one write, both channels offered together
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1;
      wvalid <= 1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (!bvalid);
   endtask : wr

   // one read, compared with expectation
   task rc(input logic [7:0] a, input logic [31:0] e);
      araddr <= a;
      arvalid <= 1;
      do @(posedge aclk); while (!arready);
      arvalid <= 0;
      do @(posedge aclk); while (!rvalid);
      chk("rdata", e, rdata);
   endtask : rc

   task end_sim;
      if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim

   // watchdog
   initial begin
      #50us;
      n_mismatch++;
      end_sim;
   end

   initial begin
      {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata, wstrb} <= 0;
      bready <= 1;
      rready <= 1;
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      rc(`OFS_CAL_CFG, 32'h0);
      chk("wren", 32'h0, 32'(wren));
      for (i = 0; i < 4; i++) begin
         wr(`OFS_PWR_CTL, 32'(i), 4'h1);
         chk("src", 32'(i), 32'(src));
      end
      wr(`OFS_UNLOCK_KEY, 32'h55, 4'h1);
      wr(`OFS_UNLOCK_KEY, 32'haa, 4'h1);
      wr(`OFS_CAL_CFG, 32'h2300, 4'h3);
      chk("wren", 32'h1, 32'(wren));
      rc(`OFS_CAL_CFG, 32'h2300);
      wr(`OFS_TIME_WIN, 32'h0099, 4'h3);
      wr(`OFS_TIME_WIN, 32'h0c1f, 4'h3);
      wr(`OFS_TIME_WIN, 32'h0017, 4'h1);
      rc(`OFS_CAL_CFG, 32'h2100);
      wr(`OFS_TIME_WIN, 32'h0300, 4'h2);
      wr(`OFS_TIME_WIN, 32'h2d1e, 4'h3);
      rc(`OFS_CAL_CFG, 32'h2000);
      wr(`OFS_CAL_CFG, 32'h2300, 4'h3);
      for (i = 0; i < 5; i++) rc(`OFS_TIME_WIN, 32'(tv[i]));
      rc(`OFS_CAL_CFG, 32'h2000);
      wr(`OFS_CAL_CFG, 32'h0, 4'h3);
      chk("wren", 32'h0, 32'(wren));
      wr(`OFS_TIME_WIN, 32'hffff, 4'h3);
      rc(`OFS_TIME_WIN, 32'h2d1e);
      wr(`OFS_CAL_CFG, 32'h2000, 4'h3);
      chk("wren", 32'h0, 32'(wren));
      // enable refused once another write follows the key
      wr(`OFS_UNLOCK_KEY, 32'h55, 4'h1);
      wr(`OFS_UNLOCK_KEY, 32'haa, 4'h1);
      wr(`OFS_PWR_CTL, 32'h3, 4'h1);
      chk("src", 32'h3, 32'(src));
      wr(`OFS_CAL_CFG, 32'h2000, 4'h3);
      chk("wren", 32'h0, 32'(wren));
      wr(`OFS_ALM_CFG, 32'h0300, 4'h2);
      for (i = 0; i < 4; i++) wr(`OFS_ALM_WIN, 32'(av[i]), 4'h3);
      rc(`OFS_ALM_CFG, 32'h0);
      wr(`OFS_ALM_CFG, 32'h0300, 4'h2);
      for (i = 0; i < 4; i++) rc(`OFS_ALM_WIN, i ? 32'(av[i]) : 32'h0);
      rc(`OFS_ALM_CFG, 32'h0);
      wr(8'h40, 32'h1234, 4'hf);
      chk("bresp", 32'h2, 32'(bresp));
      rc(8'h40, 32'h0);
      chk("rresp", 32'h2, 32'(rresp));
      rc(`OFS_UNLOCK_KEY, 32'h0);
      end_sim;
   end
endmodule : tb_calendar_clock_unit
